//--- include/pxbr_arb_if.sv
// carrier between the bridge top and its bus arbiter
`timescale 1ns/10ps
`default_nettype none
interface pxbr_arb_if;
  logic [6:0] req;
  logic [6:0] gnt;
  logic       bus_idle;
  logic [7:0] ctrl;
  logic [7:0] mask;
  logic [5:0] tstat;
  modport arb (input req, bus_idle, ctrl, mask, output gnt, tstat);
  modport top (output req, bus_idle, ctrl, mask, input gnt, tstat);
endinterface
`default_nettype wire

//--- include/pxbr_pkg.sv
// constants and types of the secondary-side bridge logic
package pxbr_pkg;
  // configuration byte offsets
  localparam logic [7:0] OFS_SEC_BUS   = 8'h19;
  localparam logic [7:0] OFS_SUB_BUS   = 8'h1A;
  localparam logic [7:0] OFS_GEN_CTL1  = 8'hD5;
  localparam logic [7:0] OFS_ARB_CTL   = 8'hDC;
  localparam logic [7:0] OFS_ARB_MASK  = 8'hDD;
  localparam logic [7:0] OFS_ARB_TSTAT = 8'hDE;
  // reset values: bridge in high tier, externals in low tier
  localparam logic [7:0] RST_ARB_CTL   = 8'h40;
  localparam logic [7:0] RST_ARB_MASK  = 8'h00;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  // field positions
  localparam int BIT_PARK       = 7;
  localparam int BIT_TMR_EN     = 7;
  localparam int BIT_AUTO_MASK  = 6;
  localparam int BIT_LOCK_EN    = 4;  // bit 12 of general control
  localparam int BRIDGE_IDX     = 6;
  localparam int N_EXT          = 6;
  // timing
  localparam int GNT_TIMEOUT_CLKS = 16;
  localparam int CLK_MHZ          = 25;
  localparam int PME_PERIOD_US    = 1000;
  localparam int PME_RESEND_CYC   = PME_PERIOD_US * CLK_MHZ;
  // upstream message kinds
  localparam logic [1:0] MSG_ASSERT   = 2'h0;
  localparam logic [1:0] MSG_DEASSERT = 2'h1;
  localparam logic [1:0] MSG_PME      = 2'h2;
  localparam logic [7:0] PME_TAG      = 8'h00;
  localparam logic [1:0] T1_LOW_BITS  = 2'h1;
  // lock sequencer states
  typedef enum logic [2:0] {
    LK_IDLE   = 3'b000,
    LK_ARB    = 3'b001,
    LK_BACKOF = 3'b010,
    LK_ADDR   = 3'b011,
    LK_WAITD  = 3'b100,
    LK_LOCKED = 3'b101,
    LK_DRAIN  = 3'b110
  } pxbr_lk_t;
endpackage

//--- src/pxbr_arb.sv
// two-tier classic bus arbiter with parking, masks and grant timeout
`timescale 1ns/10ps
`default_nettype none
module pxbr_arb (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // link to top
  pxbr_arb_if.arb  a
);
  logic [6:0] gnt_q, gnt_d;
  logic [5:0] tstat_q, amask_q;
  logic [3:0] tmr_q;
  wire  [6:0] eff, hi, lo, sel, park;
  wire        ext_g, tmo, rsp_wait;

  // lowest index wins inside a tier
  function automatic logic [6:0] pick(input logic [6:0] v);
    pick = v & (~v + 7'h01);
  endfunction

  // masked requests split into tiers
  assign eff   = a.req & ~{1'b0, a.mask[5:0] | amask_q};
  assign hi    = eff & a.ctrl[6:0];
  assign lo    = eff & ~a.ctrl[6:0];
  assign sel   = (|hi) ? pick(hi) : pick(lo);
  assign park  = a.ctrl[pxbr_pkg::BIT_PARK] ? gnt_q : 7'h40;
  assign ext_g = |gnt_q[5:0];
  // a parked master that asks for nothing owes no response
  assign rsp_wait = |(gnt_q[5:0] & eff[5:0]);
  assign tmo   = rsp_wait && a.bus_idle && (tmr_q == 4'(pxbr_pkg::GNT_TIMEOUT_CLKS - 1));
  assign gnt_d = !a.bus_idle ? gnt_q : tmo ? 7'h00
               : (|(gnt_q & eff)) ? gnt_q : (|eff) ? sel : park;
  assign a.gnt   = gnt_q;
  assign a.tstat = tstat_q;

  // grant only moves while the bus is idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      gnt_q <= 7'h40;
    end else begin
      gnt_q <= gnt_d;
    end
  end

  // idle clocks since grant; a started frame is the response
  always_ff @(posedge CLK) begin
    if (RST || !rsp_wait || !a.bus_idle || tmo) begin
      tmr_q <= 4'h0;
    end else begin
      tmr_q <= tmr_q + 4'h1;
    end
  end

  // sticky status and auto masks, wiped when their enable drops
  always_ff @(posedge CLK) begin
    if (RST || !a.mask[pxbr_pkg::BIT_TMR_EN]) begin
      tstat_q <= 6'h00;
    end else if (tmo) begin
      tstat_q <= tstat_q | gnt_q[5:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST || !a.mask[pxbr_pkg::BIT_AUTO_MASK]) begin
      amask_q <= 6'h00;
    end else if (tmo) begin
      amask_q <= amask_q | gnt_q[5:0];
    end
  end

  property p_onehot_gnt;
    @(posedge CLK) disable iff (RST) $onehot0(gnt_q);
  endproperty
  a_onehot_gnt: assert property (p_onehot_gnt) else $error("more than one grant");

  property p_tmo_status;
    @(posedge CLK) disable iff (RST)
      (tmo && a.mask[7]) |=> ((tstat_q & $past(gnt_q[5:0])) != 6'h00);
  endproperty
  a_tmo_status: assert property (p_tmo_status) else $error("timeout not recorded");

  property p_mask_blocks;
    @(posedge CLK) disable iff (RST)
      (a.bus_idle && !ext_g && a.mask[2]) |=> !gnt_q[2];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked master granted");
endmodule
`default_nettype wire

//--- src/pxbr_top.sv
// secondary-side bridge: arbiter regs, config translation, messages, lock
`timescale 1ns/10ps
`default_nettype none
module pxbr_top #(
  parameter int PME_RESEND_CYC = pxbr_pkg::PME_RESEND_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // configuration register port
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // upstream configuration requests
  input  wire logic        CFG_REQ,
  input  wire logic        CFG_TYPE1,
  input  wire logic [7:0]  CFG_BUS,
  input  wire logic [4:0]  CFG_DEV,
  input  wire logic [2:0]  CFG_FUNC,
  input  wire logic [5:0]  CFG_REG,
  output logic             CFG_LOCAL,
  output logic             CFG_FWD,
  output logic             CFG_FWD_T1,
  output logic             CFG_UR,
  output logic      [31:0] CFG_AD,
  // upstream memory requests and completions
  input  wire logic        LK_RD_REQ,
  input  wire logic        MEM_RD_REQ,
  input  wire logic        MEM_WR_REQ,
  input  wire logic        UNLOCK_MSG,
  output logic             CPL_VALID,
  output logic             CPL_LOCKED,
  output logic             CPL_UR,
  output logic             UP_BLOCK,
  // secondary initiator handshake
  output logic             PCI_ISSUE,
  output logic             PCI_ISSUE_WR,
  output logic             PCI_ISSUE_LK,
  input  wire logic        PCI_ADDR_NEXT,
  input  wire logic        PCI_DATA_RET,
  input  wire logic        PCI_DONE,
  // secondary bus pins
  input  wire logic [5:0]  REQ_N,
  output logic      [5:0]  GNT_N,
  input  wire logic        FRAME_N,
  input  wire logic        IRDY_N,
  input  wire logic        LOCK_N_I,
  output logic             LOCK_N_O,
  output logic             LOCK_N_OE,
  input  wire logic [3:0]  INT_N,
  input  wire logic        PME_N,
  // upstream messages
  output logic             MSG_VALID,
  input  wire logic        MSG_READY,
  output logic      [1:0]  MSG_KIND,
  output logic      [1:0]  MSG_INTX,
  output logic      [15:0] MSG_REQID,
  output logic      [7:0]  MSG_TAG
);
  pxbr_arb_if ai ();
  pxbr_arb u_arb (.CLK(CLK), .RST(RST), .a(ai.arb));

  // configuration bytes
  logic [7:0] sec_q, sub_q, gc1_q, actl_q, amsk_q;
  wire        lock_en = gc1_q[pxbr_pkg::BIT_LOCK_EN];

  always_ff @(posedge CLK) begin
    if (RST) begin
      sec_q  <= pxbr_pkg::RST_BYTE;
      sub_q  <= pxbr_pkg::RST_BYTE;
      gc1_q  <= pxbr_pkg::RST_BYTE;
      actl_q <= pxbr_pkg::RST_ARB_CTL;
      amsk_q <= pxbr_pkg::RST_ARB_MASK;
    end else if (REG_WR) begin
      if (REG_ADDR == pxbr_pkg::OFS_SEC_BUS)  sec_q  <= REG_WDATA;
      if (REG_ADDR == pxbr_pkg::OFS_SUB_BUS)  sub_q  <= REG_WDATA;
      if (REG_ADDR == pxbr_pkg::OFS_GEN_CTL1) gc1_q  <= REG_WDATA;
      if (REG_ADDR == pxbr_pkg::OFS_ARB_CTL)  actl_q <= REG_WDATA;
      if (REG_ADDR == pxbr_pkg::OFS_ARB_MASK) amsk_q <= REG_WDATA;
    end
  end

  // read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    (REG_ADDR == pxbr_pkg::OFS_SEC_BUS)   ? sec_q  :
    (REG_ADDR == pxbr_pkg::OFS_SUB_BUS)   ? sub_q  :
    (REG_ADDR == pxbr_pkg::OFS_GEN_CTL1)  ? gc1_q  :
    (REG_ADDR == pxbr_pkg::OFS_ARB_CTL)   ? actl_q :
    (REG_ADDR == pxbr_pkg::OFS_ARB_MASK)  ? amsk_q :
    (REG_ADDR == pxbr_pkg::OFS_ARB_TSTAT) ? {2'h0, ai.tstat} : 8'h00;

  always_ff @(posedge CLK) begin
    if (RST) REG_RDATA <= 8'h00;
    else     REG_RDATA <= rd_mux;
  end

  // pin synchronisers: int[3:0], pme, frame, irdy, lock, req[5:0]
  logic [13:0] s1_q, s2_q;
  logic [4:0]  s3_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_q <= 14'h3FFF;
      s2_q <= 14'h3FFF;
      s3_q <= 5'h1F;
    end else begin
      s1_q <= {REQ_N, LOCK_N_I, IRDY_N, FRAME_N, PME_N, INT_N};
      s2_q <= s1_q;
      s3_q <= s2_q[4:0];
    end
  end
  wire [3:0] int_s  = s2_q[3:0];
  wire       pme_s  = s2_q[4];
  wire       idle_s = s2_q[5] & s2_q[6];
  wire       lock_s = s2_q[7];
  wire [5:0] req_s  = ~s2_q[13:8];

  // arbiter hookup; bridge requests on the top index
  logic br_req_q;
  assign ai.req      = {br_req_q, req_s};
  assign ai.bus_idle = idle_s;
  assign ai.ctrl     = actl_q;
  assign ai.mask     = amsk_q;
  wire   br_gnt      = ai.gnt[pxbr_pkg::BRIDGE_IDX];
  always_ff @(posedge CLK) begin
    if (RST) GNT_N <= 6'h3F;
    else     GNT_N <= ~ai.gnt[5:0];
  end

  // configuration translation
  wire        to_sec   = CFG_BUS == sec_q;
  wire        to_below = (CFG_BUS > sec_q) && (CFG_BUS <= sub_q);
  wire [15:0] idsel    = CFG_DEV[4] ? 16'h0000 : (16'h0001 << CFG_DEV[3:0]);
  wire [31:0] t0_ad    = {idsel, 5'h00, CFG_FUNC, CFG_REG, 2'h0};
  wire [31:0] t1_ad    = {8'h00, CFG_BUS, CFG_DEV, CFG_FUNC, CFG_REG,
                          pxbr_pkg::T1_LOW_BITS};
  always_ff @(posedge CLK) begin
    if (RST) begin
      CFG_LOCAL  <= 1'b0;
      CFG_FWD    <= 1'b0;
      CFG_FWD_T1 <= 1'b0;
      CFG_UR     <= 1'b0;
      CFG_AD     <= 32'h0000_0000;
    end else begin
      CFG_LOCAL  <= CFG_REQ && !CFG_TYPE1;
      CFG_FWD    <= CFG_REQ && CFG_TYPE1 && (to_sec || to_below);
      CFG_FWD_T1 <= CFG_REQ && CFG_TYPE1 && !to_sec && to_below;
      CFG_UR     <= CFG_REQ && CFG_TYPE1 && !to_sec && !to_below;
      if (CFG_REQ && CFG_TYPE1) CFG_AD <= to_sec ? t0_ad : t1_ad;
    end
  end

  // interrupt and event messages; one held until taken
  logic [3:0]  rep_q;   // interrupt level last reported
  logic [24:0] pme_tmr_q;
  logic        pme_due_q;
  wire  [3:0]  chg     = ~int_s ^ rep_q;
  wire  [3:0]  chg_one = chg & (~chg + 4'h1);
  wire         pme_fall = s3_q[4] && !pme_s;
  wire         slot     = !MSG_VALID || MSG_READY;
  wire  [1:0]  chg_idx  = chg_one[0] ? 2'h0 : chg_one[1] ? 2'h1 :
                          chg_one[2] ? 2'h2 : 2'h3;

  // resend timer runs while the event input stays low
  always_ff @(posedge CLK) begin
    if (RST || pme_s) begin
      pme_tmr_q <= 25'h0;
      pme_due_q <= 1'b0;
    end else if (pme_fall) begin
      pme_due_q <= 1'b1;
      pme_tmr_q <= 25'h0;
    end else if (pme_tmr_q == 25'(PME_RESEND_CYC - 1)) begin
      pme_due_q <= 1'b1;
      pme_tmr_q <= 25'h0;
    end else begin
      if (slot && pme_due_q && !(|chg)) pme_due_q <= 1'b0;
      pme_tmr_q <= pme_tmr_q + 25'h1;
    end
  end

  // interrupt changes take precedence over the event message
  always_ff @(posedge CLK) begin
    if (RST) begin
      rep_q     <= 4'h0;
      MSG_VALID <= 1'b0;
      MSG_KIND  <= pxbr_pkg::MSG_ASSERT;
      MSG_INTX  <= 2'h0;
      MSG_REQID <= 16'h0000;
      MSG_TAG   <= 8'h00;
    end else if (slot) begin
      MSG_VALID <= (|chg) || pme_due_q;
      if (|chg) begin
        rep_q    <= rep_q ^ chg_one;
        MSG_KIND <= (|(chg_one & ~int_s)) ? pxbr_pkg::MSG_ASSERT
                                          : pxbr_pkg::MSG_DEASSERT;
        MSG_INTX <= chg_idx;
      end else begin
        MSG_KIND  <= pxbr_pkg::MSG_PME;
        MSG_REQID <= {sec_q, 8'h00};
        MSG_TAG   <= pxbr_pkg::PME_TAG;
      end
    end
  end

  // locked transaction sequencer
  pxbr_pkg::pxbr_lk_t lk_q, lk_d;
  logic [3:0] outst_q;
  wire  issue_wr = MEM_WR_REQ;
  wire  issue_lk = (lk_q == pxbr_pkg::LK_ARB) && br_gnt && lock_s;
  wire  issue_nl = (LK_RD_REQ && !lock_en && lk_q == pxbr_pkg::LK_IDLE)
                || (MEM_RD_REQ && lk_q != pxbr_pkg::LK_LOCKED);
  wire  owned    = (lk_q == pxbr_pkg::LK_WAITD) || (lk_q == pxbr_pkg::LK_LOCKED)
                || (lk_q == pxbr_pkg::LK_DRAIN);
  wire  any_iss  = issue_wr || issue_lk || issue_nl;

  always_comb begin
    lk_d = lk_q;
    case (lk_q)
      pxbr_pkg::LK_IDLE:   if (LK_RD_REQ && lock_en) lk_d = pxbr_pkg::LK_ARB;
      pxbr_pkg::LK_ARB:    if (br_gnt) lk_d = lock_s ? pxbr_pkg::LK_ADDR
                                                     : pxbr_pkg::LK_BACKOF;
      pxbr_pkg::LK_BACKOF: if (lock_s && idle_s) lk_d = pxbr_pkg::LK_ARB;
      pxbr_pkg::LK_ADDR:   if (PCI_ADDR_NEXT) lk_d = pxbr_pkg::LK_WAITD;
      pxbr_pkg::LK_WAITD:  if (PCI_DATA_RET) lk_d = pxbr_pkg::LK_LOCKED;
      pxbr_pkg::LK_LOCKED: if (UNLOCK_MSG) lk_d = pxbr_pkg::LK_DRAIN;
      pxbr_pkg::LK_DRAIN:  if (outst_q == 4'h0) lk_d = pxbr_pkg::LK_IDLE;
      default:             lk_d = pxbr_pkg::LK_IDLE;
    endcase
  end

  // state, outstanding count and bridge request
  always_ff @(posedge CLK) begin
    if (RST) begin
      lk_q     <= pxbr_pkg::LK_IDLE;
      outst_q  <= 4'h0;
      br_req_q <= 1'b0;
    end else begin
      lk_q     <= lk_d;
      outst_q  <= outst_q + {3'h0, any_iss} - {3'h0, PCI_DONE && outst_q != 4'h0};
      br_req_q <= (lk_d == pxbr_pkg::LK_ARB) || (outst_q != 4'h0);
    end
  end

  // initiator commands and upstream completions
  always_ff @(posedge CLK) begin
    if (RST) begin
      PCI_ISSUE    <= 1'b0;
      PCI_ISSUE_WR <= 1'b0;
      PCI_ISSUE_LK <= 1'b0;
      CPL_VALID    <= 1'b0;
      CPL_LOCKED   <= 1'b0;
      CPL_UR       <= 1'b0;
      UP_BLOCK     <= 1'b0;
    end else begin
      PCI_ISSUE    <= any_iss;
      PCI_ISSUE_WR <= issue_wr;
      PCI_ISSUE_LK <= issue_lk || (issue_wr && owned);
      CPL_VALID    <= (lk_q == pxbr_pkg::LK_WAITD && PCI_DATA_RET)
                   || (MEM_RD_REQ && lk_q == pxbr_pkg::LK_LOCKED);
      CPL_LOCKED   <= lk_q == pxbr_pkg::LK_WAITD && PCI_DATA_RET;
      CPL_UR       <= MEM_RD_REQ && lk_q == pxbr_pkg::LK_LOCKED;
      UP_BLOCK     <= lk_d == pxbr_pkg::LK_LOCKED || lk_d == pxbr_pkg::LK_DRAIN;
    end
  end

  // lock pin: low while owned, high in locked address phases
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOCK_N_O  <= 1'b1;
      LOCK_N_OE <= 1'b0;
    end else begin
      LOCK_N_OE <= lock_en && (lk_d == pxbr_pkg::LK_WAITD || lk_d == pxbr_pkg::LK_LOCKED
                   || lk_d == pxbr_pkg::LK_DRAIN);
      LOCK_N_O  <= PCI_ADDR_NEXT;
    end
  end

  property p_lock_en;
    @(posedge CLK) disable iff (RST) !lock_en |=> !LOCK_N_OE;
  endproperty
  a_lock_en: assert property (p_lock_en) else $error("lock driven while disabled");

  property p_ur_locked;
    @(posedge CLK) disable iff (RST)
      (MEM_RD_REQ && lk_q == pxbr_pkg::LK_LOCKED) |=> (CPL_VALID && CPL_UR);
  endproperty
  a_ur_locked: assert property (p_ur_locked) else $error("no UR for read while locked");

  property p_idsel;
    @(posedge CLK) disable iff (RST)
      (CFG_REQ && CFG_TYPE1 && to_sec) |=> (CFG_FWD && !CFG_FWD_T1 && $onehot0(CFG_AD[31:16])
        && (CFG_AD[1:0] == 2'h0));
  endproperty
  a_idsel: assert property (p_idsel) else $error("bad type 0 conversion");

  property p_type0_local;
    @(posedge CLK) disable iff (RST) (CFG_REQ && !CFG_TYPE1) |=> (CFG_LOCAL && !CFG_FWD);
  endproperty
  a_type0_local: assert property (p_type0_local) else $error("type 0 forwarded");

  property p_backoff;
    @(posedge CLK) disable iff (RST)
      (lk_q == pxbr_pkg::LK_ARB && br_gnt && !lock_s) |=> ##1 !br_req_q;
  endproperty
  a_backoff: assert property (p_backoff) else $error("no back off on busy lock");

  property p_pme_first;
    @(posedge CLK) disable iff (RST)
      (pme_fall && !(|chg) && slot) |=> ##[1:8] (MSG_VALID && MSG_KIND == pxbr_pkg::MSG_PME
        && MSG_TAG == 8'h00);
  endproperty
  a_pme_first: assert property (p_pme_first) else $error("event message missing");
endmodule
`default_nettype wire

//--- verif/pxbr_pci_model.sv
// behavioural secondary bus: external masters, targets and the lock line
`timescale 1ns/10ps
`default_nettype none
module pxbr_pci_model (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // bench controls
  input  wire logic [5:0] want,
  input  wire logic [5:0] mute,
  input  wire logic       other_lock,
  input  wire logic       slow,
  // bridge side
  input  wire logic [5:0] GNT_N,
  input  wire logic       PCI_ISSUE,
  input  wire logic       PCI_ISSUE_WR,
  input  wire logic       LOCK_N_O,
  input  wire logic       LOCK_N_OE,
  output logic      [5:0] REQ_N,
  output logic            FRAME_N,
  output logic            IRDY_N,
  output logic            LOCK_N_I,
  output logic            PCI_ADDR_NEXT,
  output logic            PCI_DATA_RET,
  output logic            PCI_DONE
);
  logic [3:0] st_q;
  logic [1:0] mst_q;
  logic       wr_q;
  logic       start;
  // a muted master never leaves idle after its grant
  assign start = |(~GNT_N & want & ~mute) && mst_q == 2'h0 && st_q == 4'h0;
  // bridge command: wait, address next, address, data, done
  always @(posedge CLK) begin
    if (RST) begin
      st_q <= 4'h0;
      mst_q <= 2'h0;
      wr_q <= 1'b0;
    end else begin
      if (PCI_ISSUE) begin
        st_q <= slow ? 4'h9 : 4'h4;
        wr_q <= PCI_ISSUE_WR;
      end else if (st_q != 4'h0) begin
        st_q <= st_q - 4'h1;
      end
      if (start) begin
        mst_q <= 2'h3;
      end else if (mst_q != 2'h0) begin
        mst_q <= mst_q - 2'h1;
      end
    end
  end
  assign REQ_N = ~want;
  assign PCI_ADDR_NEXT = st_q == 4'h4;
  assign PCI_DATA_RET = st_q == 4'h2 && !wr_q;
  assign PCI_DONE = st_q == 4'h1;
  assign FRAME_N = !(st_q == 4'h3 || mst_q[1]);
  assign IRDY_N = !((st_q != 4'h0 && st_q < 4'h4) || mst_q != 2'h0);
  // pulled up; low while another owner holds it or the bridge drives it low
  assign LOCK_N_I = (LOCK_N_OE ? LOCK_N_O : 1'b1) & !other_lock;
endmodule
`default_nettype wire

//--- verif/pxbr_tb_top.sv
// self-checking bench for the secondary-side bridge logic
`timescale 1ns/10ps
`default_nettype none
module pxbr_tb_top;
  localparam int RESEND = 20;
  localparam logic [7:0] SEC = 8'h05;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic REG_WR, CFG_REQ, CFG_TYPE1, LK_RD_REQ, MEM_RD_REQ, MEM_WR_REQ, UNLOCK_MSG;
  logic MSG_READY, PME_N, FRAME_N, IRDY_N, LOCK_N_I, PCI_ADDR_NEXT, PCI_DATA_RET, PCI_DONE;
  logic CFG_LOCAL, CFG_FWD, CFG_FWD_T1, CFG_UR, CPL_VALID, CPL_LOCKED, CPL_UR, UP_BLOCK;
  logic PCI_ISSUE, PCI_ISSUE_WR, PCI_ISSUE_LK, LOCK_N_O, LOCK_N_OE, MSG_VALID, other_lock, slow;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, CFG_BUS, MSG_TAG;
  logic [5:0]  CFG_REG, REQ_N, GNT_N, want, mute;
  logic [4:0]  CFG_DEV;
  logic [3:0]  INT_N;
  logic [2:0]  CFG_FUNC;
  logic [1:0]  MSG_KIND, MSG_INTX;
  logic [15:0] MSG_REQID;
  logic [31:0] CFG_AD, r;
  logic [31:0] lfsr = 32'h00018070;
  logic [17:0] ev;
  int          c, f, o;
  int          failures = 0;
  int          n_tests = 0;

  pxbr_top #(.PME_RESEND_CYC(RESEND)) dut (
    .CLK, .RST, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .CFG_REQ, .CFG_TYPE1, .CFG_BUS,
    .CFG_DEV, .CFG_FUNC, .CFG_REG, .CFG_LOCAL, .CFG_FWD, .CFG_FWD_T1, .CFG_UR, .CFG_AD,
    .LK_RD_REQ, .MEM_RD_REQ, .MEM_WR_REQ, .UNLOCK_MSG, .CPL_VALID, .CPL_LOCKED, .CPL_UR,
    .UP_BLOCK, .PCI_ISSUE, .PCI_ISSUE_WR, .PCI_ISSUE_LK, .PCI_ADDR_NEXT, .PCI_DATA_RET,
    .PCI_DONE, .REQ_N, .GNT_N, .FRAME_N, .IRDY_N, .LOCK_N_I, .LOCK_N_O, .LOCK_N_OE, .INT_N,
    .PME_N, .MSG_VALID, .MSG_READY, .MSG_KIND, .MSG_INTX, .MSG_REQID, .MSG_TAG
  );
  pxbr_pci_model model (
    .CLK, .RST, .want, .mute, .other_lock, .slow, .GNT_N, .PCI_ISSUE, .PCI_ISSUE_WR,
    .LOCK_N_O, .LOCK_N_OE, .REQ_N, .FRAME_N, .IRDY_N, .LOCK_N_I, .PCI_ADDR_NEXT,
    .PCI_DATA_RET, .PCI_DONE
  );

  always #20 CLK = ~CLK;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // address phase word expected for a forwarded request
  function automatic logic [31:0] exp_ad(input logic [7:0] b, input logic [4:0] d,
                                         input logic [2:0] fn, input logic [5:0] g);
    if (b == SEC) begin
      return {(d[4] ? 16'h0000 : 16'h0001 << d[3:0]), 5'h00, fn, g, 2'h0};
    end
    return {8'h00, b, d, fn, g, 2'h1};
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs always move one nanosecond after the rising edge; settled outputs
  // then go into a sticky record, so one-cycle pulses are never missed
  task automatic tick();
    @(posedge CLK);
    #1;
    ev = ev | {MSG_VALID, !LOCK_N_OE && !UP_BLOCK, ~GNT_N, PCI_ISSUE, LOCK_N_OE, CPL_UR,
               CPL_VALID && CPL_LOCKED, PCI_ISSUE && PCI_ISSUE_LK && PCI_ISSUE_WR,
               PCI_ISSUE && PCI_ISSUE_LK && !PCI_ISSUE_WR, CFG_UR, CFG_FWD_T1, CFG_FWD,
               CFG_LOCAL};
  endtask
  task automatic run(input int n);
    repeat (n) tick();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    tick();
    REG_WR = 1'b0;
    tick();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    REG_ADDR = a;
    run(2);
    chk(nm, e, REG_RDATA);
  endtask
  task automatic wait_ev(input int b, input int lim);
    int k;
    k = 0;
    while (ev[b] !== 1'b1 && k < lim) begin
      tick();
      k++;
    end
    chk($sformatf("event %0d", b), 1, ev[b]);
    if (ev[b] !== 1'b1) begin
      report_and_stop();
    end
  endtask
  task automatic wait_msg(input logic [1:0] kd, input logic [1:0] ix, input int lim);
    int k;
    k = 0;
    while (MSG_VALID !== 1'b1 && k < lim) begin
      tick();
      k++;
    end
    chk("msg valid", 1, MSG_VALID);
    if (MSG_VALID !== 1'b1) begin
      report_and_stop();
    end
    chk("msg kind", kd, MSG_KIND);
    if (kd != 2'h2) begin
      chk("msg line", ix, MSG_INTX);
    end else begin
      chk("msg reqid", {SEC, 8'h00}, MSG_REQID);
      chk("msg tag", 8'h00, MSG_TAG);
    end
    MSG_READY = 1'b1;
    tick();
    MSG_READY = 1'b0;
  endtask

  initial begin
    {REG_WR, CFG_REQ, CFG_TYPE1, LK_RD_REQ, MEM_RD_REQ, MEM_WR_REQ, UNLOCK_MSG, MSG_READY} = '0;
    {REG_ADDR, REG_WDATA, CFG_BUS, CFG_DEV, CFG_FUNC, CFG_REG} = '0;
    {want, mute, other_lock, slow} = '0;
    INT_N = 4'hF;
    PME_N = 1'b1;
    run(16);
    RST = 1'b0;
    // reset values, read-only status, unmapped byte, random read-back
    rd_chk(8'hDC, 8'h40, "arb ctrl reset");
    rd_chk(8'hDD, 8'h00, "arb mask reset");
    wr(8'hDE, 8'hFF);
    rd_chk(8'hDE, 8'h00, "timeout status ro");
    wr(8'hF0, 8'hA5);
    rd_chk(8'hF0, 8'h00, "unmapped");
    r = rnd();
    wr(8'hDC, r[7:0]);
    rd_chk(8'hDC, r[7:0], "arb ctrl rw");
    wr(8'hDD, {2'h0, r[13:8]});
    rd_chk(8'hDD, {2'h0, r[13:8]}, "arb mask rw");
    wr(8'hDD, 8'h00);
    wr(8'h19, SEC);
    wr(8'h1A, 8'h09);
    $display("test registers done");
    // local, secondary, lower bus and out-of-range requests in turn
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      c = i % 4;
      CFG_REQ = 1'b1;
      CFG_TYPE1 = c != 0;
      CFG_BUS = c == 1 ? SEC : c == 2 ? SEC + 8'h01 + r[1:0] : 8'h04;
      CFG_DEV = i == 1 ? 5'h0F : i == 5 ? 5'h10 : r[6:2];
      CFG_FUNC = r[9:7];
      CFG_REG = r[15:10];
      ev = '0;
      tick();
      CFG_REQ = 1'b0;
      run(2);
      chk("cfg local", c == 0, ev[0]);
      chk("cfg fwd", c == 1 || c == 2, ev[1]);
      chk("cfg type1", c == 2, ev[2]);
      chk("cfg ur", c == 3, ev[3]);
      if (c == 1 || c == 2) begin
        chk("cfg ad", exp_ad(CFG_BUS, CFG_DEV, CFG_FUNC, CFG_REG), CFG_AD);
      end
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      INT_N[i] = 1'b0;
      wait_msg(2'h0, i[1:0], 40);
      INT_N[i] = 1'b1;
      wait_msg(2'h1, i[1:0], 40);
    end
    PME_N = 1'b0;
    wait_msg(2'h2, 2'h0, 40);
    wait_msg(2'h2, 2'h0, RESEND + 40);
    PME_N = 1'b1;
    run(4);
    ev = '0;
    run(RESEND * 3);
    chk("event msgs stop", 0, ev[17]);
    $display("test messages done");
    // parking on the bridge, then on the last grantee
    for (int j = 0; j < 2; j++) begin
      wr(8'hDC, j ? 8'hC0 : 8'h40);
      ev = '0;
      want = 6'h04;
      wait_ev(12, 20);
      want = 6'h00;
      run(20);
      chk("park", j ? 6'h3B : 6'h3F, GNT_N);
    end
    // same tier: lowest index first; master 4 promoted wins
    for (int j = 0; j < 2; j++) begin
      wr(8'hDC, j ? 8'h50 : 8'h40);
      run(10);
      ev = '0;
      f = j ? 4 : 1;
      o = j ? 1 : 4;
      want = 6'h12;
      wait_ev(10 + f, 20);
      chk("tier order", 0, ev[10 + o]);
      want[f] = 1'b0;
      wait_ev(10 + o, 40);
      want = 6'h00;
    end
    wr(8'hDC, 8'h40);
    wr(8'hDD, 8'h04);
    ev = '0;
    want = 6'h04;
    run(30);
    chk("masked request", 0, ev[12]);
    wr(8'hDD, 8'h00);
    wait_ev(12, 20);
    want = 6'h00;
    // silent master: status only after sixteen idle clocks
    wr(8'hDD, 8'h80);
    mute = 6'h08;
    want = 6'h08;
    ev = '0;
    wait_ev(13, 20);
    run(8);
    rd_chk(8'hDE, 8'h00, "timeout early");
    run(12);
    rd_chk(8'hDE, 8'h08, "timeout status");
    want = 6'h00;
    wr(8'hDD, 8'h00);
    rd_chk(8'hDE, 8'h00, "timeout cleared");
    wr(8'hDD, 8'hC0);
    mute = 6'h10;
    want = 6'h10;
    ev = '0;
    wait_ev(14, 20);
    run(30);
    ev = '0;
    run(30);
    chk("auto mask", 0, ev[14]);
    mute = 6'h00;
    wr(8'hDD, 8'h80);
    wait_ev(14, 40);
    want = 6'h00;
    wr(8'hDD, 8'h00);
    $display("test arbiter done");
    // lock disabled: plain read, pin never driven
    ev = '0;
    LK_RD_REQ = 1'b1;
    tick();
    LK_RD_REQ = 1'b0;
    wait_ev(9, 60);
    run(12);
    chk("lock pin off", 0, ev[8]);
    // lock taken by another owner before the request, so the synchronised
    // lock line is already low when the bridge first sees its grant
    other_lock = 1'b1;
    wr(8'hD5, 8'h10);
    r = rnd();
    slow = r[0];
    ev = '0;
    LK_RD_REQ = 1'b1;
    tick();
    LK_RD_REQ = 1'b0;
    run(30);
    chk("lock busy backoff", 0, ev[4]);
    other_lock = 1'b0;
    wait_ev(4, 60);
    wait_ev(8, 30);
    wait_ev(6, 30);
    run(2);
    chk("blocked", 1, UP_BLOCK);
    chk("lock pin low", 0, LOCK_N_O);
    MEM_WR_REQ = 1'b1;
    tick();
    MEM_WR_REQ = 1'b0;
    wait_ev(5, 40);
    MEM_RD_REQ = 1'b1;
    tick();
    MEM_RD_REQ = 1'b0;
    wait_ev(7, 10);
    chk("lock held", 1, LOCK_N_OE);
    ev = '0;
    UNLOCK_MSG = 1'b1;
    tick();
    UNLOCK_MSG = 1'b0;
    wait_ev(16, 40);
    $display("test lock done");
    report_and_stop();
  end
endmodule
`default_nettype wire
